// ---- rtl/sac_top.sv ----
//
// Behaviour
// - two mode bits pick input configuration
// - serial clock shifts data and steps SAR
// - external reference at reset; bit selects internal
// - twos complement default; coding bit gives binary
// - sequence uses coding from latest control write
// - reset leaves eight single-ended inputs
// - each channel holds its own range
// - thirteen-bit result spans 8192 codes
// - track resumes on 14th rising serial edge
// - power-down chosen by control field
// - select falling edge enters hold
//
`timescale 1ns/1ps
module sac_top #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // serial link pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  // converter core
  input  wire logic        cmp_in,
  output logic [12:0]      dac_code,
  output logic             track,
  output sac_pkg::sac_mux_t mux_sel,
  output logic [1:0]       range_sel,
  output logic             ref_int,
  output sac_pkg::sac_pm_t pd_mode,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] pin_reg;
  logic [2:0] pin_prev_reg;
  wire  [2:0] agree    = s2_reg ~^ s3_reg;
  wire  [2:0] pin_next = (agree & s3_reg) | (~agree & pin_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg       <= 3'h7;
      s2_reg       <= 3'h7;
      s3_reg       <= 3'h7;
      pin_reg      <= 3'h7;
      pin_prev_reg <= 3'h7;
    end else begin
      s1_reg       <= {din, sclk, cs_n};
      s2_reg       <= s1_reg;
      s3_reg       <= s2_reg;
      pin_reg      <= pin_next;
      pin_prev_reg <= pin_reg;
    end
  end

  wire cs_act    = ~pin_reg[0];
  wire cs_fall   = pin_prev_reg[0] & ~pin_reg[0];
  wire cs_rise   = ~pin_prev_reg[0] & pin_reg[0];
  wire sclk_rise = cs_act & ~pin_prev_reg[1] & pin_reg[1];
  wire sclk_fall = cs_act & pin_prev_reg[1] & ~pin_reg[1];
  wire din_s     = pin_reg[2];

  // ---------------------------------------------------------------
  // configuration state
  // ---------------------------------------------------------------
  sac_pkg::sac_ctrl_t ctrl_reg;      // active settings
  sac_pkg::sac_ctrl_t ctrl_pend_reg; // last written, not yet live
  logic [15:0]        range_reg;
  logic [15:0]        range_pend_reg;
  logic [1:0]         config_reg;
  logic [2:0]         chan_reg;

  // config bit0 allows conversions, bit1 freezes the output drain
  wire conv_en    = config_reg[0];
  wire drain_hold = config_reg[1];

  // ---------------------------------------------------------------
  // frame engine
  // ---------------------------------------------------------------
  logic [4:0]  edge_cnt_reg;
  logic [15:0] rx_reg;
  logic [4:0]  rx_cnt_reg;
  logic [15:0] tx_reg;
  logic [12:0] sar_reg;
  logic        run_reg;
  logic        track_reg;
  logic        dout_reg;
  logic        oe_reg;
  logic        push_reg;
  logic [15:0] push_data_reg;
  logic        pend_ctrl_reg;
  logic        pend_rng_reg;
  logic [15:0] frame_cnt_reg;

  wire        fifo_in_ready;
  wire [15:0] fifo_out_data;
  wire        fifo_out_valid;
  wire [$clog2(FIFO_DEPTH):0] fifo_level;
  wire        fifo_pop = cs_fall & fifo_out_valid & ~drain_hold;

  wire [4:0]  edge_nxt = (edge_cnt_reg == 5'h1F) ? edge_cnt_reg
                                                 : edge_cnt_reg + 5'h01;
  wire [3:0]  sar_bit  = 4'(sac_pkg::TRACK_EDGE - int'(edge_nxt));
  wire        sar_step = run_reg & sclk_rise
                       & (edge_nxt >= 5'(sac_pkg::SAR_FIRST_EDGE))
                       & (edge_nxt <= 5'(sac_pkg::TRACK_EDGE));
  wire        sar_done = sar_step & (edge_nxt == 5'(sac_pkg::TRACK_EDGE));
  wire [15:0] rx_word  = {rx_reg[14:0], din_s};
  wire [1:0]  rx_addr  = rx_reg[sac_pkg::ADDR_HI:sac_pkg::ADDR_LO];
  wire        rx_wr    = (rx_cnt_reg >= 5'(sac_pkg::FRAME_BITS))
                       & rx_reg[sac_pkg::WR_BIT];

  // keep the already-decided upper bits, try the next lower one
  function automatic logic [12:0] sar_next(input logic [12:0] cur,
                                           input logic [3:0]  k,
                                           input logic        keep);
    logic [12:0] v;
    v    = cur;
    v[k] = keep;
    if (k != 4'h0) begin
      v[k-1'b1] = 1'b1;
    end
    return v;
  endfunction

  // sequence walks from 0 up to the programmed channel and wraps
  wire [2:0] seq_chan = (chan_reg >= ctrl_pend_reg.chan) ? 3'h0
                                                         : chan_reg + 3'h1;
  wire [2:0] next_chan = (ctrl_pend_reg.seq != 2'h0) ? seq_chan
                                                     : ctrl_pend_reg.chan;
  // bit flip of the msb turns offset binary into twos complement
  wire [12:0] coded = ctrl_reg.coding ? sar_reg
                    : {~sar_reg[12], sar_reg[11:0]};

  always_ff @(posedge clk) begin
    if (rst) begin
      edge_cnt_reg <= '0;
      rx_reg       <= '0;
      rx_cnt_reg   <= '0;
      tx_reg       <= '0;
      sar_reg      <= '0;
      run_reg      <= 1'b0;
      track_reg    <= 1'b1;
      dout_reg     <= 1'b0;
      oe_reg       <= 1'b0;
      chan_reg     <= 3'h0;
    end else if (cs_fall) begin
      track_reg    <= 1'b0;
      edge_cnt_reg <= '0;
      rx_cnt_reg   <= '0;
      chan_reg     <= next_chan;
      // a full fifo holds the converter idle rather than lose a result
      run_reg      <= conv_en & fifo_in_ready
                    & (ctrl_pend_reg.pm != sac_pkg::SAC_PM_FULLSD);
      sar_reg      <= 13'h1000;
      tx_reg       <= fifo_pop ? {fifo_out_data[14:0], 1'b0} : '0;
      dout_reg     <= fifo_pop ? fifo_out_data[15] : 1'b0;
      oe_reg       <= 1'b1;
    end else if (cs_rise) begin
      oe_reg  <= 1'b0;
      run_reg <= 1'b0;
    end else begin
      if (sclk_rise) begin
        edge_cnt_reg <= edge_nxt;
        rx_reg       <= rx_word;
        rx_cnt_reg   <= (rx_cnt_reg == 5'h1F) ? rx_cnt_reg
                                              : rx_cnt_reg + 5'h01;
        if (edge_nxt == 5'(sac_pkg::TRACK_EDGE)) begin
          track_reg <= 1'b1;
        end
      end
      if (sar_step) begin
        sar_reg <= sar_next(sar_reg, sar_bit, cmp_in);
      end
      if (sar_done) begin
        run_reg <= 1'b0;
      end
      if (sclk_fall) begin
        dout_reg <= tx_reg[15];
        tx_reg   <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  // the last decision lands in sar_reg at the edge that raises this
  // flag, so the coded word is read a cycle later, never mid-update
  logic last_step_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      last_step_reg <= 1'b0;
    end else begin
      last_step_reg <= sar_done;
    end
  end

  // result word enters the fifo two cycles after the last decision
  always_ff @(posedge clk) begin
    if (rst) begin
      push_reg      <= 1'b0;
      push_data_reg <= '0;
      frame_cnt_reg <= '0;
    end else begin
      push_reg <= 1'b0;
      if (last_step_reg) begin
        push_reg      <= 1'b1;
        push_data_reg <= {chan_reg, coded};
        frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // serial register writes
  // ---------------------------------------------------------------
  wire [12:0] pay = rx_reg[12:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_pend_reg  <= sac_pkg::CTRL_RST;
      range_pend_reg <= '0;
      pend_ctrl_reg  <= 1'b0;
      pend_rng_reg   <= 1'b0;
    end else if (cs_rise && rx_wr) begin
      unique case (rx_addr)
        sac_pkg::ADDR_CTRL: begin
          ctrl_pend_reg.chan    <= pay[sac_pkg::CF_CHAN_LO +: 3];
          ctrl_pend_reg.mode    <= sac_pkg::sac_mode_t'(
                                   pay[sac_pkg::CF_MODE_LO +: 2]);
          ctrl_pend_reg.pm      <= sac_pkg::sac_pm_t'(
                                   pay[sac_pkg::CF_PM_LO +: 2]);
          ctrl_pend_reg.coding  <= pay[sac_pkg::CF_CODING];
          ctrl_pend_reg.ref_int <= pay[sac_pkg::CF_REF];
          ctrl_pend_reg.seq     <= pay[sac_pkg::CF_SEQ_LO +: 2];
          pend_ctrl_reg         <= 1'b1;
        end
        sac_pkg::ADDR_RANGE1: begin
          range_pend_reg[7:0] <= pay[sac_pkg::RF_LO +: 8];
          pend_rng_reg        <= 1'b1;
        end
        sac_pkg::ADDR_RANGE2: begin
          range_pend_reg[15:8] <= pay[sac_pkg::RF_LO +: 8];
          pend_rng_reg         <= 1'b1;
        end
        default: begin
          pend_rng_reg <= pend_rng_reg;
        end
      endcase
    end else if (cs_fall) begin
      pend_ctrl_reg <= 1'b0;
      pend_rng_reg  <= 1'b0;
    end
  end

  // written settings go live only at the next select fall
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg  <= sac_pkg::CTRL_RST;
      range_reg <= '0;
    end else if (cs_fall) begin
      ctrl_reg  <= ctrl_pend_reg;
      range_reg <= range_pend_reg;
    end
  end

  // ---------------------------------------------------------------
  // converter core controls
  // ---------------------------------------------------------------
  sac_pkg::sac_mux_t mux_next;
  sac_pkg::sac_mux_t mux_reg;
  logic [1:0]        range_out_reg;

  always_comb begin
    mux_next = '0;
    unique case (ctrl_reg.mode)
      sac_pkg::SAC_MODE_SE8: begin
        mux_next.pos = chan_reg;
      end
      sac_pkg::SAC_MODE_PSD4: begin
        mux_next.pos    = {chan_reg[2:1], 1'b0};
        mux_next.neg    = {chan_reg[2:1], 1'b1};
        mux_next.neg_en = 1'b1;
      end
      sac_pkg::SAC_MODE_DIFF4: begin
        mux_next.pos    = {chan_reg[2:1], 1'b0};
        mux_next.neg    = {chan_reg[2:1], 1'b1};
        mux_next.neg_en = 1'b1;
        mux_next.diff   = 1'b1;
      end
      sac_pkg::SAC_MODE_PSD7: begin
        mux_next.pos    = (chan_reg == 3'h7) ? 3'h6 : chan_reg;
        mux_next.neg    = 3'h7;
        mux_next.neg_en = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mux_reg       <= '0;
      range_out_reg <= 2'h0;
    end else begin
      mux_reg       <= mux_next;
      range_out_reg <= range_reg[{chan_reg, 1'b0} +: 2];
    end
  end

  // ---------------------------------------------------------------
  // result fifo
  // ---------------------------------------------------------------
  sac_fifo #(
    .WIDTH (sac_pkg::FRAME_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (push_data_reg),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .level     (fifo_level)
  );

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  wire         acc     = psel & penable;
  wire         hit_st  = (paddr == sac_pkg::OFS_STATUS);
  wire         hit_ctl = (paddr == sac_pkg::OFS_CTRL);
  wire         hit_rng = (paddr == sac_pkg::OFS_RANGE);
  wire         hit_cfg = (paddr == sac_pkg::OFS_CONFIG);
  wire         mapped  = hit_st | hit_ctl | hit_rng | hit_cfg;
  wire [31:0]  st_word = {frame_cnt_reg, 6'h00,
                          6'($unsigned(fifo_level)),
                          pend_rng_reg, pend_ctrl_reg, cs_act, track_reg};
  wire [31:0]  rd_mux  = hit_st  ? st_word
                       : hit_ctl ? 32'(ctrl_reg)
                       : hit_rng ? {16'h0000, range_reg}
                       : hit_cfg ? {30'h00000000, config_reg}
                       : 32'h00000000;

  always_ff @(posedge clk) begin
    if (rst) begin
      config_reg  <= sac_pkg::CONFIG_RST;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= 1'b0;
      if (psel && !penable) begin
        prdata_reg  <= rd_mux;
        pslverr_reg <= ~mapped;
      end
      if (acc && pwrite && hit_cfg) begin
        config_reg <= pwdata[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dout      = dout_reg;
  assign dout_oe   = oe_reg;
  assign dac_code  = sar_reg;
  assign track     = track_reg;
  assign mux_sel   = mux_reg;
  assign range_sel = range_out_reg;
  assign ref_int   = ctrl_reg.ref_int;
  assign pd_mode   = ctrl_reg.pm;
  assign prdata    = prdata_reg;
  assign pready    = 1'b1;
  // set in the setup cycle, so it stands exactly in the access cycle
  assign pslverr   = pslverr_reg;

endmodule

// ---- rtl/sac_pkg.sv ----
package sac_pkg;

  // ---------------------------------------------------------------
  // serial frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS     = 16;
  localparam int RES_BITS       = 13;
  localparam int CODES          = 8192;
  localparam int CH_BITS        = 3;
  localparam int NUM_CH         = 8;
  localparam int WR_BIT         = 15;
  localparam int ADDR_HI        = 14;
  localparam int ADDR_LO        = 13;
  localparam int TRACK_EDGE     = 14;
  localparam int SAR_FIRST_EDGE = 2;
  localparam logic [1:0] ADDR_CTRL   = 2'h0;
  localparam logic [1:0] ADDR_RANGE1 = 2'h1;
  localparam logic [1:0] ADDR_RANGE2 = 2'h2;

  // control payload field positions
  localparam int CF_CHAN_LO = 10;
  localparam int CF_MODE_LO = 8;
  localparam int CF_PM_LO   = 6;
  localparam int CF_CODING  = 5;
  localparam int CF_REF     = 4;
  localparam int CF_SEQ_LO  = 2;
  localparam int RF_LO      = 5;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ       = 40;
  localparam int SCLK_FULL_MHZ = 20;
  localparam int FRAME_NS      = 1000;
  localparam int FRAME_CYCLES  = FRAME_NS * CLK_MHZ / 1000;

  // ---------------------------------------------------------------
  // apb map
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_CTRL   = 12'h004;
  localparam logic [11:0] OFS_RANGE  = 12'h008;
  localparam logic [11:0] OFS_CONFIG = 12'h00C;
  localparam logic [1:0]  CONFIG_RST = 2'h1;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SAC_MODE_SE8   = 2'h0,
    SAC_MODE_PSD4  = 2'h1,
    SAC_MODE_DIFF4 = 2'h2,
    SAC_MODE_PSD7  = 2'h3
  } sac_mode_t;

  typedef enum logic [1:0] {
    SAC_PM_NORMAL  = 2'h0,
    SAC_PM_AUTOSTB = 2'h1,
    SAC_PM_AUTOSD  = 2'h2,
    SAC_PM_FULLSD  = 2'h3
  } sac_pm_t;

  typedef struct packed {
    logic [2:0] chan;
    sac_mode_t  mode;
    sac_pm_t    pm;
    logic       coding;
    logic       ref_int;
    logic [1:0] seq;
  } sac_ctrl_t;

  localparam sac_ctrl_t CTRL_RST = '{chan: 3'h0, mode: SAC_MODE_SE8,
    pm: SAC_PM_NORMAL, coding: 1'b0, ref_int: 1'b0, seq: 2'h0};

  typedef struct packed {
    logic [2:0] pos;
    logic [2:0] neg;
    logic       neg_en;
    logic       diff;
  } sac_mux_t;

endpackage

// ---- rtl/sac_fifo.sv ----
`timescale 1ns/1ps
module sac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (cnt_reg < (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign level     = cnt_reg;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- dv/sac_host_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host serial controller
// ---------------------------------------------------------------
module sac_host_model (
  input  wire logic clk,
  input  wire logic dout,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  logic din_bit;
  logic idle_pat = 1'b0;

  initial begin
    cs_n    = 1'b1;
    sclk    = 1'b1;
    din_bit = 1'b0;
  end

  // released line toggles so a stale bit never passes for a real one
  always @(posedge clk) idle_pat <= ~idle_pat;
  assign din = cs_n ? idle_pat : din_bit;

  // link clock idles high and runs only inside a frame, 8 clk period
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      rx[i] = dout;
      sclk    <= 1'b0;
      din_bit <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ---- dv/sac_top_chk.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// link and bus checks at the top ports
// ---------------------------------------------------------------
module sac_top_chk (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              cs_n,
  input wire logic              sclk,
  input wire logic              din,
  input wire logic              dout,
  input wire logic              dout_oe,
  input wire logic              cmp_in,
  input wire logic [12:0]       dac_code,
  input wire logic              track,
  input wire sac_pkg::sac_mux_t mux_sel,
  input wire logic [1:0]        range_sel,
  input wire logic              ref_int,
  input wire sac_pkg::sac_pm_t  pd_mode,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr
);
  logic       sclk_q;
  logic       cs_q;
  logic [4:0] edge_cnt;
  logic [3:0] fall_age;
  wire        sclk_rise = sclk & ~sclk_q;
  wire        norm      = pd_mode == sac_pkg::SAC_PM_NORMAL;

  // raw pins are counted; the design lags them by its synchroniser
  always_ff @(posedge clk) begin
    sclk_q   <= sclk;
    cs_q     <= cs_n;
    edge_cnt <= (rst || cs_n) ? 5'h00 : edge_cnt + {4'h0, sclk_rise};
    fall_age <= (rst || (cs_q && !cs_n)) ? 4'h0
              : fall_age + {3'h0, fall_age != 4'hF};
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_sel_fall;
    $fell(cs_n) && norm;
  endsequence
  sequence s_oe_on;
    ##[1:8] dout_oe;
  endsequence

  a_reset_state: assert property (disable iff (1'b0)
    $fell(rst) |-> track && !ref_int && !dout_oe && norm && mux_sel == '0)
    else $error("state after reset is wrong");
  a_hold_on_select: assert property (s_sel_fall |-> ##[1:8] !track)
    else $error("hold not entered after select fall");
  a_track_at_14: assert property (
    sclk_rise && !cs_n && norm && edge_cnt == 5'h0D |-> ##[1:8] track)
    else $error("track not resumed after 14th edge");
  a_no_early_track: assert property (
    !track && !cs_n && norm && edge_cnt <= 5'h0C |=> !track)
    else $error("track resumed too early");
  a_oe_in_frame: assert property ($fell(cs_n) |-> s_oe_on)
    else $error("data out not enabled in frame");
  a_oe_idle: assert property (cs_n [*6] |-> !dout_oe)
    else $error("data out enabled while idle");
  a_dac_quiet: assert property (
    track && $past(track) |-> $stable(dac_code))
    else $error("code moved while tracking");
  a_cfg_at_frame: assert property (
    $changed({ref_int, pd_mode, range_sel, mux_sel}) |-> fall_age <= 4'hA)
    else $error("setting changed outside frame start");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("access not answered");
  a_err_unmapped: assert property (psel && penable && paddr > 12'h00C
    |-> pslverr)
    else $error("unmapped access not refused");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
endmodule

bind sac_top sac_top_chk u_chk (.clk, .rst, .cs_n, .sclk, .din, .dout,
  .dout_oe, .cmp_in, .dac_code, .track, .mux_sel, .range_sel, .ref_int,
  .pd_mode, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr);

// ---- dv/test_sac_top.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// converter control bench
// ---------------------------------------------------------------
module test_sac_top;
  localparam int DEPTH = 4;
  logic clk = 1'b0, rst = 1'b1, cmp_in = 1'b0, hold = 1'b0, conv = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, seed = 32'hE1D2055A;
  logic cs_n, sclk, din, dout, dout_oe, track, ref_int, pready, pslverr;
  logic [12:0] dac_code;
  logic [1:0] range_sel;
  logic [31:0] prdata;
  sac_pkg::sac_mux_t mux_sel;
  sac_pkg::sac_pm_t pd_mode;
  sac_pkg::sac_ctrl_t cur = sac_pkg::CTRL_RST, pend = sac_pkg::CTRL_RST;
  logic [1:0] rc [8] = '{default: 2'h0};
  logic [1:0] rp [8] = '{default: 2'h0};
  logic [2:0] seq_ch = 3'h0;
  logic [15:0] q [$];
  int error_cnt = 0;
  int tests_run = 0;

  always #12.5 clk = ~clk;

  sac_top #(.FIFO_DEPTH(DEPTH)) uut (.clk, .rst, .cs_n, .sclk, .din, .dout,
    .dout_oe, .cmp_in, .dac_code, .track, .mux_sel, .range_sel, .ref_int,
    .pd_mode, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  sac_host_model host (.clk, .dout, .cs_n, .sclk, .din);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // comparator held constant: raw code all ones or zeros, sign bit flips unless cod is set
  function automatic logic [12:0] res(input logic cmp, input logic cod);
    return {13{cmp}} ^ (cod ? 13'h0000 : 13'h1000);
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    tests_run++;
    if (seen !== want) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [32:0] rsp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rsp = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic run(input logic [15:0] tx, input logic cmp);
    logic [15:0] rx;
    logic [15:0] want;
    logic [2:0]  ch;
    logic        room;
    cur = pend;
    rc = rp;
    // sequence steps on from the channel converted last, then wraps
    seq_ch = (cur.seq == 2'h0) ? cur.chan
           : (seq_ch >= cur.chan) ? 3'h0 : seq_ch + 3'h1;
    ch = seq_ch;
    // room is judged before this frame's pop, as the fifo sees it
    room = q.size() < DEPTH;
    want = (!hold && q.size() != 0) ? q.pop_front() : 16'h0000;
    cmp_in <= cmp;
    host.frame(tx, rx);
    if (!hold) check(rx, want);
    check({range_sel, ref_int, pd_mode, mux_sel.diff, mux_sel.neg_en},
      {rc[ch], cur.ref_int, cur.pm, cur.mode == sac_pkg::SAC_MODE_DIFF4,
       cur.mode != sac_pkg::SAC_MODE_SE8});
    if (cur.mode == sac_pkg::SAC_MODE_SE8) check(mux_sel.pos, ch);
    if (conv && cur.pm != sac_pkg::SAC_PM_FULLSD && room)
      q.push_back({ch, res(cmp, cur.coding)});
    if (tx[15] && tx[14:13] == sac_pkg::ADDR_CTRL)
      pend = sac_pkg::sac_ctrl_t'(tx[12:2]);
    else if (tx[15])
      for (int c = 0; c < 4; c++)
        rp[c + 4 * (tx[14:13] == sac_pkg::ADDR_RANGE2)] = tx[5 + 2 * c +: 2];
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    logic [32:0] r;
    logic [15:0] tx;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({track, ref_int, pd_mode, mux_sel}, 12'h800);
    apb(1'b0, sac_pkg::OFS_CONFIG, 32'h0, r);
    check({r[32], r[1:0]}, {1'b0, sac_pkg::CONFIG_RST});
    apb(1'b1, 12'h010, 32'hFFFFFFFF, r);
    check(r[32], 1'b1);
    apb(1'b0, 12'h010, 32'h0, r);
    check(r, {1'b1, 32'h0});
    // every input mode and all converting power modes, random fields
    for (int i = 0; i < 15; i++) begin
      seed = xs(seed);
      tx = seed[15:0];
      if (i % 3 == 0)
        tx[15:2] = {3'h4, seed[18:16], 2'(i / 3), 2'(i / 3 % 3),
                    seed[20:19], 2'h0};
      else if (i % 3 == 1) tx[15:13] = {1'b1, seed[17], ~seed[17]};
      else tx[15] = 1'b0;
      run(tx, seed[21]);
    end
    run({3'h4, 3'h2, 2'h0, 2'h1, 2'h2, 2'h1, 2'h0}, 1'b1);
    for (int i = 0; i < 4; i++) run(i == 1 ? 16'hD5E0 : 16'h0, i[0]);
    // fill until refused while the drain is held, then pop one word per frame for DEPTH + 1 frames
    apb(1'b1, sac_pkg::OFS_CONFIG, 32'h3, r);
    hold = 1'b1;
    for (int i = 0; i < DEPTH + 2; i++) run(16'h0, i[0]);
    apb(1'b1, sac_pkg::OFS_CONFIG, 32'h1, r);
    hold = 1'b0;
    for (int i = 0; i <= DEPTH; i++) run(16'h0, 1'b0);
    apb(1'b1, sac_pkg::OFS_CONFIG, 32'h0, r);
    conv = 1'b0;
    run(16'h0, 1'b1);
    apb(1'b1, sac_pkg::OFS_CONFIG, 32'h1, r);
    conv = 1'b1;
    run({3'h4, 3'h0, 2'h0, 2'h3, 4'h0, 2'h0}, 1'b0);
    hold = 1'b1;
    run(16'h0, 1'b0);
    tally_and_finish();
  end
endmodule
